// ===== image_copy_rotate_engine.sv
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "rot_engine_regs.svh"
// Summary of operation
// - copy equals zero rotation without mirror
// - rgb kept, yuv written as planar 420
// - rgb word or yuv byte per access
// - start bit starts job, self clears
// - soft reset bit holds engine in reset
// - burst length field, reset 0x3f
// - bit 7 horizontal, bit 6 vertical mirror
// - field 5:4 selects clockwise rotation
// - mode 00 disabled, 01 copy rotate
// - finish flag set at end, w1c
// - finish interrupt enabled by bit 16
// - format codes 0x00-0x07 are rgb orders
// - yuv codes 0x24-0x2a decoded
// - height and width are field plus one
// - 40-bit address from low and high
// - sizes 8x8 up to 8192x8192
// - one plane moved for rgb, three for yuv
module image_copy_rotate_engine (
   input  logic                  clk_sys_in,
   input  logic                  sys_rst_in,
   input  logic [7:0]            avs_address_in,
   input  logic                  avs_read_in,
   input  logic                  avs_write_in,
   input  logic [31:0]           avs_writedata_in,
   input  logic [3:0]            avs_byteenable_in,
   output logic [31:0]           avs_readdata_out,
   output logic                  avs_waitrequest_out,
   output rot_engine_pkg::addr_t mem_address_out,
   output logic                  mem_read_out,
   output logic                  mem_write_out,
   output logic [31:0]           mem_writedata_out,
   output logic [3:0]            mem_byteenable_out,
   output logic [5:0]            mem_burst_len_out,
   input  logic                  mem_waitrequest_in,
   input  logic [31:0]           mem_readdata_in,
   input  logic                  mem_readdatavalid_in,
   output logic                  irq_out
);
   import rot_engine_pkg::*;

   // ---------------------------------------------------------
   // helper functions
   // ---------------------------------------------------------
   function automatic logic [5:0] widx(input logic [7:0] a);
      widx = a[7:2];
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] be);
      be_merge = o;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            be_merge[8*i +: 8] = n[8*i +: 8];
         end
      end
   endfunction

   // writable and readable bits per offset, zero when unmapped
   function automatic logic [31:0] reg_mask(input logic [7:0] a);
      case (a)
         `ROT_OFF_CTRL:    reg_mask = `ROT_CTL_MASK;
         `ROT_OFF_IRQ:     reg_mask = `ROT_IRQ_MASK;
         `ROT_OFF_SRC_FMT: reg_mask = `ROT_FMT_MASK;
         `ROT_OFF_SRC_DIM,
         `ROT_OFF_DST_DIM: reg_mask = `ROT_DIM_MASK;
         `ROT_OFF_SRC_BHI0, `ROT_OFF_SRC_BHI1, `ROT_OFF_SRC_BHI2,
         `ROT_OFF_DST_BHI0, `ROT_OFF_DST_BHI1,
         `ROT_OFF_DST_BHI2: reg_mask = `ROT_HI_MASK;
         `ROT_OFF_SRC_STR0, `ROT_OFF_SRC_STR1, `ROT_OFF_SRC_STR2,
         `ROT_OFF_SRC_BLO0, `ROT_OFF_SRC_BLO1, `ROT_OFF_SRC_BLO2,
         `ROT_OFF_DST_STR0, `ROT_OFF_DST_STR1, `ROT_OFF_DST_STR2,
         `ROT_OFF_DST_BLO0, `ROT_OFF_DST_BLO1,
         `ROT_OFF_DST_BLO2: reg_mask = `ROT_FULL_MASK;
         default:          reg_mask = 32'h0;
      endcase
   endfunction

   // output pixel to source pixel, mirror applied in source space
   function automatic logic [25:0] map_xy(input logic [12:0] ox,
      input logic [12:0] oy, input logic [13:0] w,
      input logic [13:0] h, input logic [1:0] rot,
      input logic hf, input logic vf);
      logic [12:0] sx;
      logic [12:0] sy;
      logic [12:0] wm;
      logic [12:0] hm;
      wm = 13'(w - 14'h1);
      hm = 13'(h - 14'h1);
      unique case (rot)
         2'h0: begin
            sx = ox;
            sy = oy;
         end
         2'h1: begin
            sx = oy;
            sy = 13'(hm - ox);
         end
         2'h2: begin
            sx = 13'(wm - ox);
            sy = 13'(hm - oy);
         end
         2'h3: begin
            sx = 13'(wm - oy);
            sy = ox;
         end
      endcase
      if (hf) begin
         sx = 13'(wm - sx);
      end
      if (vf) begin
         sy = 13'(hm - sy);
      end
      map_xy = {sx, sy};
   endfunction

   function automatic addr_t addr_of(input addr_t base,
      input logic [12:0] y, input logic [31:0] pitch,
      input logic [14:0] off);
      addr_of = 40'(base + 40'(y) * 40'(pitch) + 40'(off));
   endfunction

   // chroma planes are half size in both directions
   function automatic logic [13:0] plane_dim(input logic [13:0] d,
      input logic [1:0] p);
      plane_dim = (p == 2'h0) ? d : {1'b0, d[13:1]};
   endfunction

   // ---------------------------------------------------------
   // register bus slave
   // ---------------------------------------------------------
   logic [31:0] cfg_ff [0:63];
   logic [31:0] ctl_ff;
   logic        fin_ff;
   logic        irq_en_ff;
   logic        ack_ff;
   logic [31:0] rdata_ff;
   logic        wr_acc_bus;
   logic        wr_ctl;
   logic        wr_irq;
   logic        set_start;
   eng_state_t  st_ff;

   // one wait cycle per access, then the answer
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_ff;
   assign wr_acc_bus = avs_write_in & ack_ff;
   assign wr_ctl = wr_acc_bus & (avs_address_in == `ROT_OFF_CTRL);
   assign wr_irq = wr_acc_bus & (avs_address_in == `ROT_OFF_IRQ);
   assign set_start = avs_byteenable_in[3] &
                      avs_writedata_in[`ROT_CTL_START];
   assign avs_readdata_out = rdata_ff;

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (avs_read_in | avs_write_in) & ~ack_ff;
      end
   end

   // read data sampled in the wait cycle, unmapped reads zero
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         rdata_ff <= 32'h0;
      end else if (avs_read_in & ~ack_ff) begin
         case (avs_address_in)
            `ROT_OFF_CTRL: rdata_ff <= ctl_ff;
            `ROT_OFF_IRQ:  rdata_ff <= {15'h0, irq_en_ff, 15'h0, fin_ff};
            default: rdata_ff <= cfg_ff[widx(avs_address_in)] &
                                 reg_mask(avs_address_in);
         endcase
      end
   end

   // plain configuration words
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < 64; i++) begin
            cfg_ff[i] <= 32'h0;
         end
      end else if (wr_acc_bus && !wr_ctl && !wr_irq) begin
         cfg_ff[widx(avs_address_in)] <=
            be_merge(cfg_ff[widx(avs_address_in)], avs_writedata_in,
                     avs_byteenable_in) & reg_mask(avs_address_in);
      end
   end

   // control word, start cleared by the engine unless set again
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         ctl_ff <= `ROT_CTL_RESET;
      end else begin
         if (wr_ctl) begin
            ctl_ff <= be_merge(ctl_ff, avs_writedata_in,
                               avs_byteenable_in) & `ROT_CTL_MASK;
         end
         if (st_ff == ST_DONE && !(wr_ctl && set_start)) begin
            ctl_ff[`ROT_CTL_START] <= 1'b0;
         end
      end
   end

   // finish flag: hardware set wins over write one to clear
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         fin_ff <= 1'b0;
         irq_en_ff <= 1'b0;
      end else begin
         fin_ff <= (st_ff == ST_DONE) |
                   (fin_ff & ~(wr_irq & avs_byteenable_in[0] &
                               avs_writedata_in[`ROT_IRQ_FINISH]));
         if (wr_irq && avs_byteenable_in[2]) begin
            irq_en_ff <= avs_writedata_in[`ROT_IRQ_EN];
         end
      end
   end

   assign irq_out = fin_ff & irq_en_ff;
   assign mem_burst_len_out = ctl_ff[21:16];

   // ---------------------------------------------------------
   // job decode
   // ---------------------------------------------------------
   logic        eng_rst;
   logic        go;
   logic [5:0]  fmt;
   logic        is_yuv;
   logic        is422;
   logic        semi;
   logic        u_odd;
   logic [1:0]  nplanes;
   logic [13:0] sw;
   logic [13:0] sh;
   logic [13:0] dw;
   logic [13:0] dh;

   assign eng_rst = sys_rst_in | ctl_ff[`ROT_CTL_SRST];
   assign go = (st_ff == ST_IDLE) & ctl_ff[`ROT_CTL_START] &
               (ctl_ff[1:0] == `ROT_MODE_COPY);
   assign fmt = cfg_ff[widx(`ROT_OFF_SRC_FMT)][5:0];
   // 0x00-0x07 rgb words; 0x24-0x2a yuv, bit 3 marks 420
   assign is_yuv = fmt[5];
   assign is422 = ~fmt[3];
   assign semi = is_yuv & ~fmt[1];
   assign u_odd = fmt[0];
   assign nplanes = is_yuv ? 2'h3 : 2'h1;
   // sizes are register fields plus one
   assign sw = 14'(cfg_ff[widx(`ROT_OFF_SRC_DIM)][12:0]) + 14'h1;
   assign sh = 14'(cfg_ff[widx(`ROT_OFF_SRC_DIM)][28:16]) + 14'h1;
   assign dw = 14'(cfg_ff[widx(`ROT_OFF_DST_DIM)][12:0]) + 14'h1;
   assign dh = 14'(cfg_ff[widx(`ROT_OFF_DST_DIM)][28:16]) + 14'h1;

   // ---------------------------------------------------------
   // pixel counters
   // ---------------------------------------------------------
   logic [12:0] ox_ff;
   logic [12:0] oy_ff;
   logic [1:0]  plane_ff;
   logic [12:0] nxt_ox;
   logic [12:0] nxt_oy;
   logic [1:0]  nxt_plane;
   logic        wr_acc;
   logic        x_last;
   logic        y_last;
   logic        last_px;

   assign wr_acc = (st_ff == ST_WR) & ~mem_waitrequest_in;
   assign x_last = ox_ff == 13'(plane_dim(dw, plane_ff) - 14'h1);
   assign y_last = oy_ff == 13'(plane_dim(dh, plane_ff) - 14'h1);
   assign last_px = x_last & y_last &
                    (plane_ff == 2'(nplanes - 2'h1));

   // raster walk over the output planes
   always_comb begin
      nxt_ox = ox_ff;
      nxt_oy = oy_ff;
      nxt_plane = plane_ff;
      if (go) begin
         nxt_ox = 13'h0;
         nxt_oy = 13'h0;
         nxt_plane = 2'h0;
      end else if (wr_acc) begin
         if (x_last) begin
            nxt_ox = 13'h0;
            if (y_last) begin
               nxt_oy = 13'h0;
               nxt_plane = 2'(plane_ff + 2'h1);
            end else begin
               nxt_oy = 13'(oy_ff + 13'h1);
            end
         end else begin
            nxt_ox = 13'(ox_ff + 13'h1);
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (eng_rst) begin
         ox_ff <= 13'h0;
         oy_ff <= 13'h0;
         plane_ff <= 2'h0;
      end else begin
         ox_ff <= nxt_ox;
         oy_ff <= nxt_oy;
         plane_ff <= nxt_plane;
      end
   end

   // ---------------------------------------------------------
   // address generation
   // ---------------------------------------------------------
   logic [1:0]  sp;
   logic [25:0] sxy;
   logic [12:0] syc;
   logic [14:0] soff;
   logic [14:0] doff;
   addr_t       src_a;
   addr_t       dst_a;

   // semi-planar v samples live in the interleaved u/v plane
   assign sp = (semi && nxt_plane == 2'h2) ? 2'h1 : nxt_plane;
   assign sxy = map_xy(nxt_ox, nxt_oy, plane_dim(sw, nxt_plane),
                       plane_dim(sh, nxt_plane), ctl_ff[5:4],
                       ctl_ff[`ROT_CTL_HFLIP], ctl_ff[`ROT_CTL_VFLIP]);
   // 422 chroma has full height, keep every other line
   assign syc = (nxt_plane != 2'h0 && is422) ?
                {sxy[11:0], 1'b0} : sxy[12:0];
   always_comb begin
      soff = {2'h0, sxy[25:13]};
      if (nxt_plane == 2'h0 && !is_yuv) begin
         soff = {sxy[25:13], 2'h0};
      end else if (nxt_plane != 2'h0 && semi) begin
         soff = 15'({sxy[25:13], 1'b0} +
                    14'((nxt_plane == 2'h1) ? u_odd : ~u_odd));
      end
   end
   assign doff = (plane_ff == 2'h0 && !is_yuv) ?
                 {ox_ff, 2'h0} : {2'h0, ox_ff};
   // 40-bit base from high byte over low word
   assign src_a = addr_of(
      {cfg_ff[6'(widx(`ROT_OFF_SRC_BHI0) + {sp, 1'b0})][7:0],
       cfg_ff[6'(widx(`ROT_OFF_SRC_BLO0) + {sp, 1'b0})]},
      syc, cfg_ff[6'(widx(`ROT_OFF_SRC_STR0) + 6'(sp))], soff);
   assign dst_a = addr_of(
      {cfg_ff[6'(widx(`ROT_OFF_DST_BHI0) + {plane_ff, 1'b0})][7:0],
       cfg_ff[6'(widx(`ROT_OFF_DST_BLO0) + {plane_ff, 1'b0})]},
      oy_ff, cfg_ff[6'(widx(`ROT_OFF_DST_STR0) + 6'(plane_ff))],
      doff);

   // ---------------------------------------------------------
   // engine sequencer and memory master
   // ---------------------------------------------------------
   logic [1:0] lane_ff;
   addr_t      maddr_ff;
   logic [31:0] mdata_ff;
   logic [3:0] mbe_ff;
   logic [7:0] rbyte;

   assign rbyte = mem_readdata_in[{lane_ff, 3'h0} +: 8];

   always_ff @(posedge clk_sys_in) begin
      if (eng_rst) begin
         st_ff <= ST_IDLE;
      end else begin
         unique case (st_ff)
            ST_IDLE:  if (go) st_ff <= ST_RD;
            ST_RD:    if (!mem_waitrequest_in) st_ff <= ST_RWAIT;
            ST_RWAIT: if (mem_readdatavalid_in) st_ff <= ST_WR;
            ST_WR: begin
               if (wr_acc) begin
                  st_ff <= last_px ? ST_DONE : ST_RD;
               end
            end
            ST_DONE:  st_ff <= ST_IDLE;
            default:  st_ff <= ST_IDLE;
         endcase
      end
   end

   // word-aligned accesses; yuv moves one byte lane, rgb a word
   always_ff @(posedge clk_sys_in) begin
      if (eng_rst) begin
         maddr_ff <= 40'h0;
         mdata_ff <= 32'h0;
         mbe_ff <= 4'h0;
         lane_ff <= 2'h0;
      end else if (go || (wr_acc && !last_px)) begin
         maddr_ff <= {src_a[39:2], 2'h0};
         lane_ff <= src_a[1:0];
         mbe_ff <= 4'hf;
      end else if (st_ff == ST_RWAIT && mem_readdatavalid_in) begin
         maddr_ff <= {dst_a[39:2], 2'h0};
         if (is_yuv) begin
            mdata_ff <= {4{rbyte}};
            mbe_ff <= 4'(4'h1 << dst_a[1:0]);
         end else begin
            mdata_ff <= mem_readdata_in;
            mbe_ff <= 4'hf;
         end
      end
   end

   assign mem_read_out = st_ff == ST_RD;
   assign mem_write_out = st_ff == ST_WR;
   assign mem_address_out = maddr_ff;
   assign mem_writedata_out = mdata_ff;
   assign mem_byteenable_out = mbe_ff;

   // ---------------------------------------------------------
   // assertions
   // ---------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_wr_done;
      st_ff == ST_WR && !mem_waitrequest_in;
   endsequence
   sequence s_job_end;
      st_ff == ST_DONE;
   endsequence

   property p_done_after_write;
      s_job_end |-> $past(st_ff == ST_WR && !mem_waitrequest_in);
   endproperty
   a_done_after_write: assert property (p_done_after_write)
      else $error("job ended without a final write");

   property p_finish_set;
      s_job_end |=> fin_ff;
   endproperty
   a_finish_set: assert property (p_finish_set)
      else $error("finish flag not set at job end");

   property p_start_clear;
      s_job_end ##0 !(wr_ctl && set_start) |=> !ctl_ff[31];
   endproperty
   a_start_clear: assert property (p_start_clear)
      else $error("start bit not cleared at job end");

   property p_irq_rise;
      s_job_end ##0 irq_en_ff && !wr_irq |=> irq_out;
   endproperty
   a_irq_rise: assert property (p_irq_rise)
      else $error("interrupt not raised after job end");

   property p_irq_mask;
      !irq_en_ff |-> !irq_out ##1 (irq_en_ff || !irq_out);
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("interrupt high while disabled");

   property p_soft_rst;
      ctl_ff[30] |=> st_ff == ST_IDLE && !mem_read_out;
   endproperty
   a_soft_rst: assert property (p_soft_rst)
      else $error("engine ran under soft reset");

   property p_mode_off;
      st_ff == ST_IDLE && ctl_ff[1:0] != 2'h1 |=> st_ff == ST_IDLE;
   endproperty
   a_mode_off: assert property (p_mode_off)
      else $error("engine started in disabled mode");

   property p_burst;
      wr_ctl && avs_byteenable_in[2] |=>
         mem_burst_len_out == $past(avs_writedata_in[21:16]);
   endproperty
   a_burst: assert property (p_burst)
      else $error("burst length not taken from control");

   property p_slave_ans;
      (avs_read_in || avs_write_in) |-> ##[0:1] !avs_waitrequest_out;
   endproperty
   a_slave_ans: assert property (p_slave_ans)
      else $error("register access not answered in one cycle");

   property p_last_plane;
      s_wr_done ##0 last_px |-> plane_ff == 2'(nplanes - 2'h1)
         ##1 s_job_end;
   endproperty
   a_last_plane: assert property (p_last_plane)
      else $error("job did not end after its last plane");

endmodule

// ===== mem_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// system memory behind the engine's master port
// ---------------------------------------------
module mem_model (
   input  wire logic        clk_in,
   input  wire logic        slow_in,
   input  wire logic [39:0] address_in,
   input  wire logic        read_in,
   input  wire logic        write_in,
   input  wire logic [31:0] writedata_in,
   input  wire logic [3:0]  byteenable_in,
   output logic             waitrequest_out,
   output logic [31:0]      readdata_out = 32'h0,
   output logic             readdatavalid_out = 1'b0
);
   logic [31:0] mem [0:2047];
   logic [2:0]  cnt_ff = 3'h0;
   logic [2:0]  lat_ff = 3'h0;
   logic [31:0] pend_ff;
   int          n_access = 0;
   // stall every other cycle when slow
   always @(posedge clk_in) begin
      cnt_ff <= cnt_ff + 3'h1;
   end
   assign waitrequest_out = slow_in & ~cnt_ff[0];
   // one read answer after a latency; data line scrambled when idle
   always @(posedge clk_in) begin
      readdatavalid_out <= 1'b0;
      readdata_out <= ~readdata_out;
      if (lat_ff == 3'h1) begin
         readdatavalid_out <= 1'b1;
         readdata_out <= pend_ff;
      end
      if (lat_ff != 3'h0) begin
         lat_ff <= lat_ff - 3'h1;
      end
      if (read_in && !waitrequest_out) begin
         lat_ff <= slow_in ? 3'h3 : 3'h1;
         pend_ff <= mem[address_in[12:2]];
         n_access <= n_access + 1;
      end
      if (write_in && !waitrequest_out) begin
         for (int b = 0; b < 4; b++) begin
            if (byteenable_in[b]) begin
               mem[address_in[12:2]][b*8 +: 8] <= writedata_in[b*8 +: 8];
            end
         end
         n_access <= n_access + 1;
      end
   end
endmodule

// ===== rot_engine_pkg.sv
package rot_engine_pkg;

   // engine sequencer states
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_RD    = 5'h02,
      ST_RWAIT = 5'h04,
      ST_WR    = 5'h08,
      ST_DONE  = 5'h10
   } eng_state_t;

   // 40-bit byte address of system memory
   typedef logic [39:0] addr_t;

endpackage

// ===== rot_engine_regs.svh
`ifndef ROT_ENGINE_REGS_SVH
`define ROT_ENGINE_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ROT_OFF_CTRL      8'h00
`define ROT_OFF_IRQ       8'h04
`define ROT_OFF_SRC_FMT   8'h20
`define ROT_OFF_SRC_DIM   8'h24
`define ROT_OFF_SRC_STR0  8'h30
`define ROT_OFF_SRC_STR1  8'h34
`define ROT_OFF_SRC_STR2  8'h38
`define ROT_OFF_SRC_BLO0  8'h40
`define ROT_OFF_SRC_BHI0  8'h44
`define ROT_OFF_SRC_BLO1  8'h48
`define ROT_OFF_SRC_BHI1  8'h4c
`define ROT_OFF_SRC_BLO2  8'h50
`define ROT_OFF_SRC_BHI2  8'h54
`define ROT_OFF_DST_DIM   8'h84
`define ROT_OFF_DST_STR0  8'h90
`define ROT_OFF_DST_STR1  8'h94
`define ROT_OFF_DST_STR2  8'h98
`define ROT_OFF_DST_BLO0  8'ha0
`define ROT_OFF_DST_BHI0  8'ha4
`define ROT_OFF_DST_BLO1  8'ha8
`define ROT_OFF_DST_BHI1  8'hac
`define ROT_OFF_DST_BLO2  8'hb0
`define ROT_OFF_DST_BHI2  8'hb4

// ------------------------------------------------------------
// field positions, masks and reset values
// ------------------------------------------------------------
`define ROT_CTL_START     31
`define ROT_CTL_SRST      30
`define ROT_CTL_HFLIP     7
`define ROT_CTL_VFLIP     6
`define ROT_IRQ_FINISH    0
`define ROT_IRQ_EN        16
`define ROT_CTL_RESET     32'h003f0000
`define ROT_CTL_MASK      32'hc03f00f3
`define ROT_IRQ_MASK      32'h00010001
`define ROT_FMT_MASK      32'h0000003f
`define ROT_DIM_MASK      32'h1fff1fff
`define ROT_HI_MASK       32'h000000ff
`define ROT_FULL_MASK     32'hffffffff
`define ROT_MODE_COPY     2'h1

`endif

// ===== test_image_copy_rotate_engine.sv
`timescale 1ns/1ps
module test_image_copy_rotate_engine;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   logic [7:0]            adr = 8'h00;
   logic                  rd = 1'b0;
   logic                  wr = 1'b0;
   logic                  slow = 1'b0;
   logic                  bad_hi = 1'b0;
   logic [31:0]           wd = 32'h0;
   logic [31:0]           rdat, m_wd, m_rdat, q;
   logic                  wq, m_rd, m_wr, m_wq, m_dv, irq;
   rot_engine_pkg::addr_t m_adr;
   logic [3:0]            m_be;
   logic [5:0]            blen;
   logic [7:0]            cfg [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h80,
                                      8'h40};
   int                    fail_count = 0;
   int                    n_checks = 0;
   int                    n0;
   // ---------------------------------------------
   // clock, design and memory
   // ---------------------------------------------
   always #4 clk = ~clk;
   image_copy_rotate_engine image_copy_rotate_engine_i (
      .clk_sys_in(clk), .sys_rst_in(rst), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wq), .mem_address_out(m_adr),
      .mem_read_out(m_rd), .mem_write_out(m_wr),
      .mem_writedata_out(m_wd), .mem_byteenable_out(m_be),
      .mem_burst_len_out(blen), .mem_waitrequest_in(m_wq),
      .mem_readdata_in(m_rdat), .mem_readdatavalid_in(m_dv),
      .irq_out(irq));
   mem_model mem_model_i (
      .clk_in(clk), .slow_in(slow), .address_in(m_adr), .read_in(m_rd),
      .write_in(m_wr), .writedata_in(m_wd), .byteenable_in(m_be),
      .waitrequest_out(m_wq), .readdata_out(m_rdat),
      .readdatavalid_out(m_dv));
   // upper address byte of each access comes from the high registers
   always @(negedge clk) begin
      if ((m_rd && m_adr[39:32] !== 8'h02) ||
          (m_wr && m_adr[39:32] !== 8'h03)) begin
         bad_hi <= 1'b1;
      end
   end
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one avalon access: raised after an edge, held until waitrequest is
   // sampled low at a rising edge, released right after that edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= ~w;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (wq === 1'b0) break;
      end
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (i == 50) begin
         fail_count++;
         final_report;
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   // start one job and poll until the engine clears its start bit
   task automatic run_job(input logic [31:0] c);
      int n;
      bus(1'b1, 8'h00, c);
      for (n = 0; n < 1000; n++) begin
         bus(1'b0, 8'h00, 32'h0);
         if (q[31] === 1'b0) break;
      end
      if (n == 1000) begin
         fail_count++;
         final_report;
      end
      chk(q, c & 32'h7fffffff);
   endtask
   function automatic logic [31:0] px(input int c, input int r);
      return 32'ha5000000 | 32'(r * 256 + c);
   endfunction
   // source pixel expected at output (x,y) for each job kind
   function automatic logic [31:0] exp_px(input int k, input int x,
                                          input int y);
      case (k)
         1: return px(y, 7 - x);
         2: return px(7 - x, 7 - y);
         3: return px(7 - y, x);
         4: return px(7 - x, y);
         5: return px(x, 7 - y);
         default: return px(x, y);
      endcase
   endfunction
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      int k, x, y, e;
      for (k = 0; k < 64; k++) begin
         mem_model_i.mem[64 + k] = px(k % 8, k / 8);
      end
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd_chk(8'h00, 32'h003f0000);
      chk(32'(blen), 32'h3f);
      rd_chk(8'h04, 32'h0);
      rd_chk(8'h10, 32'h0);
      bus(1'b1, 8'h24, 32'hffffffff);
      rd_chk(8'h24, 32'h1fff1fff);
      bus(1'b1, 8'h44, 32'hffffffff);
      rd_chk(8'h44, 32'h000000ff);
      n0 = mem_model_i.n_access;
      bus(1'b1, 8'h00, 32'h80070000);
      repeat (40) @(posedge clk);
      chk(32'(blen), 32'h07);
      chk(32'(mem_model_i.n_access), 32'(n0));
      bus(1'b1, 8'h00, 32'h003f0000);
      bus(1'b1, 8'h20, 32'h0);
      bus(1'b1, 8'h24, 32'h00070007);
      bus(1'b1, 8'h84, 32'h00070007);
      bus(1'b1, 8'h30, 32'h20);
      bus(1'b1, 8'h90, 32'h20);
      bus(1'b1, 8'h40, 32'h100);
      bus(1'b1, 8'h44, 32'h2);
      bus(1'b1, 8'ha0, 32'h1000);
      bus(1'b1, 8'ha4, 32'h3);
      for (k = 0; k < 6; k++) begin
         slow <= k[0];
         bus(1'b1, 8'h04, {15'h0, ~k[0], 16'h0});
         run_job(32'h803f0001 | cfg[k]);
         rd_chk(8'h04, {15'h0, ~k[0], 16'h1});
         chk(32'(irq), {31'h0, ~k[0]});
         for (y = 0; y < 8; y++) begin
            for (x = 0; x < 8; x++) begin
               q = mem_model_i.mem[1024 + y * 8 + x];
               chk(q, exp_px(k, x, y));
               mem_model_i.mem[1024 + y * 8 + x] = 32'h0;
            end
         end
         bus(1'b1, 8'h04, {15'h0, ~k[0], 16'h1});
         rd_chk(8'h04, {15'h0, ~k[0], 16'h0});
         chk(32'(irq), 32'h0);
         $display("job %0d done", k);
      end
      // planar yuv 420 at 180 degrees: each source byte names its plane,
      // row and column, so a wrong plane or position shows in the value
      for (k = 256; k < 1024; k++) begin
         mem_model_i.mem[k/4][8*(k%4) +: 8] = {k[9:8], k[7:5], k[2:0]};
      end
      bus(1'b1, 8'h20, 32'h2a);
      for (k = 1; k < 3; k++) begin
         bus(1'b1, 8'(8'h30 + 4 * k), 32'h20);
         bus(1'b1, 8'(8'h90 + 4 * k), 32'h20);
         bus(1'b1, 8'(8'h40 + 8 * k), 32'(256 * k + 256));
         bus(1'b1, 8'(8'h44 + 8 * k), 32'h2);
         bus(1'b1, 8'(8'ha0 + 8 * k), 32'(1024 * k + 4096));
         bus(1'b1, 8'(8'ha4 + 8 * k), 32'h3);
      end
      run_job(32'h803f0021);
      for (k = 0; k < 3; k++) begin
         n0 = (k == 0) ? 7 : 3;
         for (y = 0; y <= n0; y++) begin
            for (x = 0; x <= n0; x++) begin
               q = mem_model_i.mem[1024 + 256 * k + 8 * y + x / 4];
               e = (k + 1) * 64 + (n0 - y) * 8 + n0 - x;
               chk((q >> (8 * (x % 4))) & 32'hff, 32'(e));
            end
         end
      end
      rd_chk(8'h04, 32'h1);
      $display("yuv job done");
      n0 = mem_model_i.n_access;
      bus(1'b1, 8'h00, 32'hc03f0001);
      repeat (40) @(posedge clk);
      chk(32'(mem_model_i.n_access), 32'(n0));
      chk(32'(bad_hi), 32'h0);
      $display("soft reset done");
      final_report;
   end
endmodule
